/* File: rtl/serial_rx_pkg.sv */
// constants for the serial receiver status block: register map, field positions, reset values
// assumes a 32-bit AHB-Lite register bus with word-aligned registers
package serial_rx_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_STATUS_ONE   = 8'h00;
  localparam logic [7:0] OFF_DATA_LOW     = 8'h04;
  localparam logic [7:0] OFF_CONTROL      = 8'h08;
  localparam logic [7:0] OFF_DIVISOR      = 8'h0C;
  localparam logic [7:0] OFF_ALT_STATUS   = 8'h10;
  localparam logic [7:0] OFF_INT_STATUS   = 8'h14;
  localparam logic [7:0] OFF_INT_MASK     = 8'h18;

  // serial_status_one fields
  localparam int ST_RECEIVE_FULL = 5;
  localparam int ST_OVERRUN      = 3;
  localparam int ST_NOISE        = 2;
  localparam int ST_FRAMING      = 1;
  localparam int ST_PARITY       = 0;

  // serial_alt_status_one fields
  localparam int ALT_EDGE           = 7;
  localparam int ALT_MISMATCH_VALUE = 2;
  localparam int ALT_MISMATCH       = 1;
  localparam int ALT_BREAK          = 0;

  // control fields
  localparam int CTL_ALT_MAP      = 0;
  localparam int CTL_PARITY_EN    = 1;
  localparam int CTL_PARITY_ODD   = 2;
  localparam int CTL_RX_POLARITY  = 3;
  localparam int CTL_MISMATCH_EN  = 4;
  localparam int CTL_BREAK_EN     = 5;
  localparam int CTL_RX_ENABLE    = 6;

  // interrupt status / mask fields
  localparam int INT_FULL     = 0;
  localparam int INT_OVERRUN  = 1;
  localparam int INT_NOISE    = 2;
  localparam int INT_FRAMING  = 3;
  localparam int INT_PARITY   = 4;
  localparam int INT_EDGE     = 5;
  localparam int INT_MISMATCH = 6;
  localparam int INT_BREAK    = 7;

  // reset values
  localparam logic [7:0]  CONTROL_RESET = 8'h40;
  localparam logic [15:0] DIVISOR_RESET = 16'h0001;
  localparam logic [7:0]  MASK_RESET    = 8'h00;

  // oversampling: 16 ticks per bit, majority vote of ticks 7, 8 and 9
  localparam logic [3:0] PHASE_VOTE_FIRST = 4'h7;
  localparam logic [3:0] PHASE_VOTE_LAST  = 4'h9;
  localparam logic [3:0] PHASE_BIT_END    = 4'hF;
  localparam logic [2:0] DATA_BITS_LAST   = 3'h7;

  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_START  = 3'b001,
    RX_DATA   = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP   = 3'b100
  } rx_state_e;

endpackage

/* File: rtl/serial_rx_status_flags.sv */
// serial receiver with main and alternative status flags behind an AHB-Lite slave
// assumes the receive line and transmit echo are synchronous to clock; one zero-wait-state slave
//
// Function
// - an active edge of the receive line (falling, or rising with receive polarity select set) sets the edge flag; a written one clears it.
// - on a bit mismatch the sampled receive level is stored in the mismatch value bit, 0 meaning low seen where high was expected.
// - with mismatch checking enabled, a received level differing from the transmitted one sets the mismatch flag, may interrupt, and a written one clears it.
// - with break detection enabled, a received break sets the break flag, may interrupt, and a written one clears it.
// - the alternative status register is read and written only while the alternative map select bit is 1.
// - a second frame completing before the data register is read sets the overrun flag right after its stop bit.
// - on overrun the incoming frame is dropped and the data register keeps its contents.
// - overrun clears only after a status read that showed it set followed by a data read.
// - noise sets the noise flag together with receive-full, never on an overrun.
// - the noise flag clears on a status read followed by a data read.
// - a zero stop bit sets the framing error flag together with receive-full, never on an overrun or on a detected break.
// - while the framing error flag is set no new frame is received; it clears on a status read showing it then a data read.
// - with parity enabled, a parity disagreeing with the parity type sets the parity error flag with receive-full, never on overrun.
// - the parity error flag clears on a status read followed by a data read.
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
module serial_rx_status_flags
  import serial_rx_pkg::*;
#(
  parameter int ADDR_WIDTH = 8,
  parameter int DIV_WIDTH  = 16
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [ADDR_WIDTH-1:0] haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  // serial line and transmitter echo
  input  wire logic                  receiveLine,
  input  wire logic                  transmitBit,
  input  wire logic                  transmitActive,
  // interrupt
  output logic                       irq
);

  if (ADDR_WIDTH < 8 || DIV_WIDTH < 1 || DIV_WIDTH > 16) begin : g_check
    $error("serial_rx_status_flags: ADDR_WIDTH must be >= 8 and DIV_WIDTH within 1..16");
  end

  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // bus state
  logic                  wrPending;
  logic [7:0]            wrAddr;
  logic [7:0]            control;
  logic [DIV_WIDTH-1:0]  divisor;
  logic [7:0]            intStatus;
  logic [7:0]            intMask;
  // flags
  logic                  receiveFull;
  logic                  overrun;
  logic                  noise;
  logic                  framing;
  logic                  parityErr;
  logic [4:0]            seenFlags;
  logic                  edgeFlag;
  logic                  mismatchFlag;
  logic                  mismatchValue;
  logic                  breakFlag;
  logic [7:0]            dataLow;
  // receiver
  rx_state_e             state;
  logic [DIV_WIDTH-1:0]  baudCount;
  logic [3:0]            phase;
  logic [2:0]            votes;
  logic [2:0]            bitIndex;
  logic [7:0]            shift;
  logic                  frameNoise;
  logic                  parityBit;
  logic                  lineLast;
  logic [3:0]            checkPhase;
  logic [2:0]            checkVotes;

  // bus decode
  wire       accept     = hsel && htrans[1] && hready;
  wire [7:0] accAddr    = haddr[7:0];
  wire       altMap     = control[CTL_ALT_MAP];
  wire       rdStatus   = accept && !hwrite && accAddr == OFF_STATUS_ONE;
  wire       rdData     = accept && !hwrite && accAddr == OFF_DATA_LOW;
  wire       wrControl  = wrPending && wrAddr == OFF_CONTROL;
  wire       wrDivisor  = wrPending && wrAddr == OFF_DIVISOR;
  wire       wrAlt      = wrPending && wrAddr == OFF_ALT_STATUS && altMap;
  wire       wrIntStat  = wrPending && wrAddr == OFF_INT_STATUS;
  wire       wrIntMask  = wrPending && wrAddr == OFF_INT_MASK;

  wire [7:0] statusOne  = {2'b00, receiveFull, 1'b0, overrun, noise, framing, parityErr};
  wire [7:0] altStatus  = {edgeFlag, 4'h0, mismatchValue, mismatchFlag, breakFlag};
  wire [31:0] readWord  =
      accAddr == OFF_STATUS_ONE ? {24'h000000, statusOne} :
      accAddr == OFF_DATA_LOW   ? {24'h000000, dataLow} :
      accAddr == OFF_CONTROL    ? {24'h000000, control} :
      accAddr == OFF_DIVISOR    ? {{(32-DIV_WIDTH){1'b0}}, divisor} :
      accAddr == OFF_ALT_STATUS ? (altMap ? {24'h000000, altStatus} : 32'h00000000) :
      accAddr == OFF_INT_STATUS ? {24'h000000, intStatus} :
      accAddr == OFF_INT_MASK   ? {24'h000000, intMask} : 32'h00000000;

  // receiver timing: one tick per divisor cycles, 16 ticks per bit
  wire       tick       = baudCount == '0;
  wire       lineLevel  = receiveLine ^ control[CTL_RX_POLARITY];
  wire       bitVal     = majority(votes);
  wire       bitNoisy   = !(votes == 3'b000 || votes == 3'b111);
  wire       bitEnd     = tick && phase == PHASE_BIT_END;
  wire       inVote     = phase >= PHASE_VOTE_FIRST && phase <= PHASE_VOTE_LAST;
  wire       startSeen  = tick && !lineLevel && control[CTL_RX_ENABLE] && !framing;
  wire       frameDone  = state == RX_STOP && bitEnd;
  wire       stopBad    = !bitVal;
  wire       noiseAll   = frameNoise | bitNoisy;
  wire       parityOdd  = ^shift ^ parityBit;
  wire       parityBad  = control[CTL_PARITY_EN] && (parityOdd != control[CTL_PARITY_ODD]);
  wire       isBreak    = control[CTL_BREAK_EN] && shift == 8'h00 && stopBad
                          && !(control[CTL_PARITY_EN] && parityBit);
  wire       loadFrame  = frameDone && !isBreak && !receiveFull;
  wire       overrunEvt = frameDone && !isBreak && receiveFull;

  // line events
  wire       edgeEvt    = lineLast && !lineLevel;
  wire       checkPoint = transmitActive && checkPhase == PHASE_VOTE_LAST && tick;
  // the tick-9 sample is still on the line at the check point, so it joins the two stored votes here
  wire       checkLevel = majority({checkVotes[1:0], lineLevel});
  wire       mismatchEvt = control[CTL_MISMATCH_EN] && checkPoint && checkLevel != transmitBit;

  // clear-by-sequence: status read snapshots flags, data read clears the snapshot; set wins
  wire [4:0] mainFlags  = {receiveFull, overrun, noise, framing, parityErr};
  wire [4:0] clearMain  = rdData ? seenFlags : 5'h00;
  wire [4:0] setMain    = {loadFrame, overrunEvt, loadFrame && noiseAll,
                           loadFrame && stopBad, loadFrame && parityBad};
  wire [4:0] next_main  = (mainFlags & ~clearMain) | setMain;
  wire [7:0] altClear   = wrAlt ? hwdata[7:0] : 8'h00;
  wire [7:0] intEvents  = {isBreak && frameDone, mismatchEvt, edgeEvt, setMain[0], setMain[1],
                           setMain[2], setMain[3], setMain[4]};
  wire [7:0] intClear   = wrIntStat ? hwdata[7:0] : 8'h00;
  wire [7:0] next_intStatus = (intStatus & ~intClear) | intEvents;

  // bus response
  always_ff @(posedge clock) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
      wrPending <= 1'b0;
      wrAddr    <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPending <= accept && hwrite;
      wrAddr    <= accAddr;
      if (accept && !hwrite) begin
        hrdata <= readWord;
      end
    end
  end

  // software-owned registers
  always_ff @(posedge clock) begin
    if (reset) begin
      control <= CONTROL_RESET;
      divisor <= DIVISOR_RESET[DIV_WIDTH-1:0];
      intMask <= MASK_RESET;
    end else begin
      if (wrControl) begin
        control <= hwdata[7:0];
      end
      if (wrDivisor) begin
        divisor <= hwdata[DIV_WIDTH-1:0];
      end
      if (wrIntMask) begin
        intMask <= hwdata[7:0];
      end
    end
  end

  // main status flags and data register
  always_ff @(posedge clock) begin
    if (reset) begin
      {receiveFull, overrun, noise, framing, parityErr} <= 5'h00;
      seenFlags <= 5'h00;
      dataLow   <= 8'h00;
    end else begin
      {receiveFull, overrun, noise, framing, parityErr} <= next_main;
      if (rdStatus) begin
        seenFlags <= mainFlags;
      end else if (rdData) begin
        seenFlags <= 5'h00;
      end
      if (loadFrame) begin
        dataLow <= shift;
      end
    end
  end

  // alternative status flags, write one to clear, set wins
  always_ff @(posedge clock) begin
    if (reset) begin
      edgeFlag      <= 1'b0;
      mismatchFlag  <= 1'b0;
      mismatchValue <= 1'b0;
      breakFlag     <= 1'b0;
    end else begin
      edgeFlag     <= (edgeFlag && !altClear[ALT_EDGE]) || edgeEvt;
      mismatchFlag <= (mismatchFlag && !altClear[ALT_MISMATCH]) || mismatchEvt;
      breakFlag    <= (breakFlag && !altClear[ALT_BREAK]) || (isBreak && frameDone);
      if (mismatchEvt) begin
        mismatchValue <= checkLevel;
      end
    end
  end

  // interrupt status, mask and output
  always_ff @(posedge clock) begin
    if (reset) begin
      intStatus <= 8'h00;
      irq       <= 1'b0;
    end else begin
      intStatus <= next_intStatus;
      irq       <= |(next_intStatus & intMask);
    end
  end

  // bit-mismatch sampling runs on its own phase while the transmitter is active
  always_ff @(posedge clock) begin
    if (reset) begin
      checkPhase <= 4'h0;
      checkVotes <= 3'b111;
      lineLast   <= 1'b1;
    end else begin
      lineLast <= lineLevel;
      if (!transmitActive) begin
        checkPhase <= 4'h0;
      end else if (tick) begin
        checkPhase <= checkPhase + 4'h1;
        if (checkPhase >= PHASE_VOTE_FIRST && checkPhase < PHASE_VOTE_LAST) begin
          checkVotes <= {checkVotes[1:0], lineLevel};
        end
      end
    end
  end

  // baud tick divider
  always_ff @(posedge clock) begin
    if (reset) begin
      baudCount <= '0;
    end else if (tick) begin
      baudCount <= divisor - DIV_WIDTH'(1);
    end else begin
      baudCount <= baudCount - DIV_WIDTH'(1);
    end
  end

  // receive frame engine; a frame is still sampled while full so overrun is seen at its stop bit
  always_ff @(posedge clock) begin
    if (reset) begin
      state      <= RX_IDLE;
      phase      <= 4'h0;
      votes      <= 3'b111;
      bitIndex   <= 3'h0;
      shift      <= 8'h00;
      frameNoise <= 1'b0;
      parityBit  <= 1'b0;
    end else begin
      if (tick && inVote) begin
        votes <= {votes[1:0], lineLevel};
      end
      if (state != RX_IDLE && tick) begin
        phase <= phase + 4'h1;
      end
      case (state)
        RX_IDLE: begin
          phase      <= 4'h1;
          frameNoise <= 1'b0;
          bitIndex   <= 3'h0;
          if (startSeen) begin
            state <= RX_START;
          end
        end
        RX_START: begin
          if (bitEnd) begin
            frameNoise <= bitNoisy;
            state      <= bitVal ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (bitEnd) begin
            shift      <= {bitVal, shift[7:1]};
            frameNoise <= noiseAll;
            bitIndex   <= bitIndex + 3'h1;
            if (bitIndex == DATA_BITS_LAST) begin
              state <= control[CTL_PARITY_EN] ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: begin
          if (bitEnd) begin
            parityBit  <= bitVal;
            frameNoise <= noiseAll;
            state      <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (bitEnd) begin
            parityBit <= 1'b0;
            state     <= RX_IDLE;
          end
        end
        default: begin
          state <= RX_IDLE;
        end
      endcase
    end
  end

  // checks
  property p_edge_flag;
    @(posedge clock) disable iff (reset) edgeEvt |=> edgeFlag;
  endproperty
  a_edge_flag: assert property (p_edge_flag) else $error("edge flag missed an active edge");

  property p_mismatch_value;
    @(posedge clock) disable iff (reset) mismatchEvt |=> mismatchValue == !$past(transmitBit);
  endproperty
  a_mismatch_value: assert property (p_mismatch_value) else $error("mismatch value wrong");

  property p_mismatch_irq;
    @(posedge clock) disable iff (reset)
      mismatchEvt && intMask[INT_MISMATCH] |=> mismatchFlag && irq;
  endproperty
  a_mismatch_irq: assert property (p_mismatch_irq) else $error("mismatch flag or interrupt missing");

  property p_break_flag;
    @(posedge clock) disable iff (reset) frameDone && isBreak && !rdData |=> breakFlag && !$changed(receiveFull);
  endproperty
  a_break_flag: assert property (p_break_flag) else $error("break not flagged");

  property p_alt_gate;
    @(posedge clock) disable iff (reset)
      accept && !hwrite && accAddr == OFF_ALT_STATUS && !altMap |=> hrdata == 32'h00000000;
  endproperty
  a_alt_gate: assert property (p_alt_gate) else $error("alternative status readable without map select");

  property p_overrun_keep;
    @(posedge clock) disable iff (reset) overrunEvt |=> overrun && $stable(dataLow) ##1 $stable(dataLow);
  endproperty
  a_overrun_keep: assert property (p_overrun_keep) else $error("overrun not set or data disturbed");

  property p_overrun_clear;
    @(posedge clock) disable iff (reset) $fell(overrun) |-> $past(rdData && seenFlags[3]);
  endproperty
  a_overrun_clear: assert property (p_overrun_clear) else $error("overrun cleared without sequence");

  property p_no_error_on_overrun;
    @(posedge clock) disable iff (reset)
      overrunEvt && !noise && !framing && !parityErr && !rdData |=> !noise && !framing && !parityErr;
  endproperty
  a_no_error_on_overrun: assert property (p_no_error_on_overrun) else $error("error flag set on overrun");

  property p_framing_blocks;
    @(posedge clock) disable iff (reset) framing && state == RX_IDLE |=> state == RX_IDLE;
  endproperty
  a_framing_blocks: assert property (p_framing_blocks) else $error("reception while framing error set");

  property p_full_on_load;
    @(posedge clock) disable iff (reset) loadFrame |=> receiveFull && dataLow == $past(shift);
  endproperty
  a_full_on_load: assert property (p_full_on_load) else $error("frame not loaded");

  c_frame: cover property (@(posedge clock) disable iff (reset) loadFrame);
  c_overrun: cover property (@(posedge clock) disable iff (reset) overrunEvt);
  c_break: cover property (@(posedge clock) disable iff (reset) frameDone && isBreak);
  c_clear: cover property (@(posedge clock) disable iff (reset) rdData && seenFlags != 5'h00);

endmodule

/* File: verif/remote_serial_tx.sv */
// far-end serial transmitter that drives the receive line, 8 data bits sent LSB first
// assumes divisor 1, so that one bit lasts BIT_CLOCKS clocks; the line idles high
`timescale 1ns/10ps
module remote_serial_tx #(
  parameter int BIT_CLOCKS = 16
) (
  // clock and line
  input  wire logic clock,
  output logic      line
);
  initial begin
    line = 1'b1;
  end

  // a one-clock glitch at clock 8 of a bit disturbs the vote but not its outcome
  task automatic bit_out(input logic v, input logic glitch);
    for (int i = 0; i < BIT_CLOCKS; i++) begin
      @(posedge clock);
      line <= (glitch && i == 8) ? ~v : v;
    end
  endtask

  // two idle bits after the stop bit give the receiver time to finish the frame
  task automatic send(input logic [7:0] data, input logic parOn, input logic parBit,
                      input logic stopBit, input logic noisy);
    bit_out(1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      bit_out(data[i], noisy && i == 0);
    end
    if (parOn) begin
      bit_out(parBit, 1'b0);
    end
    bit_out(stopBit, 1'b0);
    bit_out(1'b1, 1'b0);
    bit_out(1'b1, 1'b0);
  endtask
endmodule

/* File: verif/serial_rx_status_flags_tb_top.sv */
// self-checking bench: AHB-Lite master tasks and a far-end transmitter on the receive line
// assumes a zero-wait-state slave with the default divisor of 1
`timescale 1ns/10ps
module serial_rx_status_flags_tb_top;
  import serial_rx_pkg::*;
  logic        clock, reset, hsel, hwrite, transmitBit, transmitActive;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire logic   hreadyout, hresp, irq, receiveLine;
  wire logic [31:0] hrdata;
  int          miscompares;
  int          samples_checked;

  serial_rx_status_flags dut (
    .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .receiveLine(receiveLine),
    .transmitBit(transmitBit), .transmitActive(transmitActive), .irq(irq)
  );
  remote_serial_tx remote (.clock(clock), .line(receiveLine));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic end_sim;
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // a hang on the bus or the interrupt ends the run as a failure
  task automatic wait_for(input bit onIrq);
    int n;
    n = 0;
    @(posedge clock);
    while ((onIrq ? irq : hreadyout) !== 1'b1) begin
      n++;
      if (n > 300) begin
        miscompares++;
        end_sim();
      end
      @(posedge clock);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    wait_for(1'b0);
    htrans <= 2'b00;
    hwdata <= d;
    wait_for(1'b0);
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(n, e, r);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  // irq is a flop loaded from next_intStatus together with the status, but it sees a mask write one cycle late
  task automatic irq_chk(input logic e);
    repeat (2) @(posedge clock);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 8'h00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    transmitBit = 1'b1;
    transmitActive = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(OFF_CONTROL, {24'h0, CONTROL_RESET}, "control");
    rd(OFF_DIVISOR, {16'h0, DIVISOR_RESET}, "divisor");
    rd(OFF_INT_MASK, {24'h0, MASK_RESET}, "mask");
    rd(8'h1C, 32'h0, "unmapped");
    remote.send(8'hA5, 1'b0, 1'b0, 1'b1, 1'b0);
    rd(OFF_ALT_STATUS, 32'h0, "alt map off");
    rd(OFF_STATUS_ONE, 32'h20, "status");
    irq_chk(1'b0);
    wr(OFF_INT_MASK, 32'h01);
    irq_chk(1'b1);
    wr(OFF_INT_STATUS, 32'h01);
    irq_chk(1'b0);
    rd(OFF_DATA_LOW, 32'hA5, "data");
    rd(OFF_STATUS_ONE, 32'h0, "status");
    // second frame arrives after the status read but before the data read
    wr(OFF_INT_MASK, 32'h00);
    remote.send(8'h11, 1'b0, 1'b0, 1'b1, 1'b0);
    rd(OFF_STATUS_ONE, 32'h20, "status");
    remote.send(8'h22, 1'b0, 1'b0, 1'b1, 1'b0);
    rd(OFF_DATA_LOW, 32'h11, "data");
    rd(OFF_STATUS_ONE, 32'h08, "status");
    rd(OFF_DATA_LOW, 32'h11, "dummy data");
    rd(OFF_STATUS_ONE, 32'h0, "status");
    remote.send(8'h5B, 1'b0, 1'b0, 1'b1, 1'b1);
    rd(OFF_STATUS_ONE, 32'h24, "status");
    rd(OFF_DATA_LOW, 32'h5B, "data");
    rd(OFF_STATUS_ONE, 32'h0, "status");
    wr(OFF_CONTROL, 32'h42);
    remote.send(8'h0F, 1'b1, 1'b1, 1'b1, 1'b0);
    rd(OFF_STATUS_ONE, 32'h21, "status");
    rd(OFF_DATA_LOW, 32'h0F, "data");
    rd(OFF_STATUS_ONE, 32'h0, "status");
    wr(OFF_CONTROL, 32'h46);
    remote.send(8'h0F, 1'b1, 1'b1, 1'b1, 1'b0);
    rd(OFF_STATUS_ONE, 32'h20, "status");
    rd(OFF_DATA_LOW, 32'h0F, "data");
    wr(OFF_CONTROL, 32'h40);
    remote.send(8'h3C, 1'b0, 1'b0, 1'b0, 1'b0);
    rd(OFF_STATUS_ONE, 32'h22, "status");
    remote.send(8'h55, 1'b0, 1'b0, 1'b1, 1'b0);
    rd(OFF_STATUS_ONE, 32'h22, "status");
    rd(OFF_DATA_LOW, 32'h3C, "data");
    rd(OFF_STATUS_ONE, 32'h0, "status");
    wr(OFF_CONTROL, 32'h61);
    wr(OFF_ALT_STATUS, 32'h87);
    rd(OFF_ALT_STATUS, 32'h0, "alt");
    wr(OFF_INT_STATUS, 32'hFF);
    wr(OFF_INT_MASK, 32'h80);
    remote.send(8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    rd(OFF_ALT_STATUS, 32'h81, "alt");
    rd(OFF_STATUS_ONE, 32'h0, "status");
    irq_chk(1'b1);
    wr(OFF_ALT_STATUS, 32'h81);
    wr(OFF_INT_STATUS, 32'hFF);
    rd(OFF_ALT_STATUS, 32'h0, "alt");
    irq_chk(1'b0);
    // with the map off a clearing write must not reach the edge flag
    wr(OFF_CONTROL, 32'h40);
    remote.send(8'h77, 1'b0, 1'b0, 1'b1, 1'b0);
    wr(OFF_ALT_STATUS, 32'h80);
    rd(OFF_STATUS_ONE, 32'h20, "status");
    rd(OFF_DATA_LOW, 32'h77, "data");
    wr(OFF_CONTROL, 32'h41);
    rd(OFF_ALT_STATUS, 32'h80, "alt");
    // receiver off, polarity select set: setting it makes one edge, then the rising line edge is the active one
    wr(OFF_CONTROL, 32'h09);
    wr(OFF_ALT_STATUS, 32'h80);
    rd(OFF_ALT_STATUS, 32'h0, "alt polarity");
    remote.send(8'hFF, 1'b0, 1'b0, 1'b1, 1'b0);
    rd(OFF_ALT_STATUS, 32'h80, "alt rising");
    wr(OFF_ALT_STATUS, 32'h80);
    wr(OFF_CONTROL, 32'h51);
    wr(OFF_INT_STATUS, 32'hFF);
    wr(OFF_INT_MASK, 32'h40);
    transmitBit <= 1'b0;
    transmitActive <= 1'b1;
    wait_for(1'b1);
    transmitActive <= 1'b0;
    rd(OFF_ALT_STATUS, 32'h06, "alt");
    wr(OFF_ALT_STATUS, 32'h02);
    wr(OFF_INT_STATUS, 32'hFF);
    irq_chk(1'b0);
    end_sim();
  end
endmodule
